// ===== verilog/clk_route_pkg.sv
// constants shared by both ends of the clock routing configuration link
// assumes: one 25 MHz clock, synchronous active-high reset at both ends
package clk_route_pkg;

  // ----------------------------------------------------------------------
  // link widths
  // ----------------------------------------------------------------------
  localparam int ADDR_W = 10;
  localparam int DATA_W = 8;

  // ----------------------------------------------------------------------
  // device register offsets
  // ----------------------------------------------------------------------
  localparam logic [9:0] PLL_FIRST_OFS = 10'h010;
  localparam logic [9:0] PLL_LAST_OFS = 10'h01E;
  localparam int PLL_CNT = 15;
  localparam logic [9:0] PWR_POL_OFS = 10'h010;
  localparam logic [9:0] VCO_CAL_OFS = 10'h018;
  localparam logic [9:0] REF_EN_OFS = 10'h01C;
  localparam logic [9:0] VCO_DIV_OFS = 10'h1E0;
  localparam logic [9:0] SRC_SEL_OFS = 10'h1E1;
  localparam logic [9:0] UPDATE_OFS = 10'h232;

  // ----------------------------------------------------------------------
  // field positions and values
  // ----------------------------------------------------------------------
  localparam int PWR_LSB = 0;
  localparam logic [1:0] PWR_NORMAL = 2'h0;
  localparam logic [1:0] PWR_DOWN = 2'h1;
  localparam int PFD_POL_BIT = 7;
  localparam int CAL_BIT = 0;
  localparam int REF_EN_LSB = 0;
  localparam int REF_EN_W = 3;
  localparam int BYPASS_BIT = 0;
  localparam int SRC_VCO_BIT = 1;
  localparam int UPDATE_BIT = 0;

  // ----------------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] PWR_POL_RST = 8'h01;
  localparam logic [7:0] VCO_DIV_RST = 8'h02;
  localparam logic [7:0] SRC_SEL_RST = 8'h00;
  localparam logic [7:0] OTHER_RST = 8'h00;

  // ----------------------------------------------------------------------
  // vco divider ratios
  // ----------------------------------------------------------------------
  localparam logic [2:0] DIV_MIN = 3'h2;
  localparam logic [2:0] DIV_MAX = 3'h6;
  localparam logic [2:0] DIV_CODE_MAX = 3'h4;
  localparam logic [2:0] DIV_ONE = 3'h1;

  // ----------------------------------------------------------------------
  // host wishbone register map (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [3:0] H_ADDR_OFS = 4'h0;
  localparam logic [3:0] H_WDATA_OFS = 4'h4;
  localparam logic [3:0] H_CTRL_OFS = 4'h8;
  localparam logic [3:0] H_STAT_OFS = 4'hC;
  localparam int H_GO_BIT = 0;
  localparam int H_WE_BIT = 1;
  localparam int H_BUSY_BIT = 0;
  localparam int H_RDATA_LSB = 8;

  typedef enum logic [1:0] {
    H_IDLE,
    H_REQ,
    H_GAP
  } host_state_t;

endpackage

// ===== verilog/clk_route_if.sv
// register link between the host controller and the clock router
// assumes: both ends share clk_i; the request is held until acknowledged
interface clk_route_if;
  logic req;
  logic we;
  logic [9:0] addr;
  logic [7:0] wdata;
  logic ack;
  logic [7:0] rdata;

  modport dev (
    input req,
    input we,
    input addr,
    input wdata,
    output ack,
    output rdata
  );

  modport host (
    output req,
    output we,
    output addr,
    output wdata,
    input ack,
    input rdata
  );
endinterface

// ===== verilog/clk_route_dev.sv
// clock source routing configuration: staged and active register sets
// assumes: the host holds req with its fields until ack, then drops it
//
// What this block does
// RL1: reset: pll off, clock input via divider
// RL2: power field 01 powers down, 00 runs
// RL3: divider field gives 2..6, resets to 4
// RL4: divider in path never below two
// RL5: bypass bit skips the vco divider
// RL6: source bit: 1 internal vco, 0 clock
// RL7: written values apply only after update write
// RL8: polarity bit: 0 positive, 1 negative
// RL9: internal vco off when clock input selected
// RL10: external vco input feeds feedback prescaler
// RL11: calibration starts when applied bit becomes one
// RL12: host clears calibration bit before recalibrating
// RL13: host keeps divider in path above 1600MHz
// RL14: host programs pll range when enabling pll
// RL15: every reference input disabled at reset
// RL16: update bit clears itself after transfer
module clk_route_dev (
  input wire logic clk_i,
  input wire logic rst_i,
  clk_route_if.dev link,
  output logic pll_on_o,
  output logic pfd_pol_neg_o,
  output logic [clk_route_pkg::REF_EN_W-1:0] ref_en_o,
  output logic src_vco_o,
  output logic div_bypass_o,
  output logic [2:0] dist_div_o,
  output logic int_vco_on_o,
  output logic fb_from_clk_in_o,
  output logic cal_start_o,
  output logic [7:0] pll_cfg_o [0:clk_route_pkg::PLL_CNT-1]
);
  import clk_route_pkg::*;

  // ----------------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------------
  // staged copies are what the host writes and reads back; active copies
  // are what the routing logic obeys
  logic [7:0] stg_pll_ff [0:PLL_CNT-1];
  logic [7:0] act_pll_ff [0:PLL_CNT-1];
  logic [7:0] stg_div_ff;
  logic [7:0] act_div_ff;
  logic [7:0] stg_src_ff;
  logic [7:0] act_src_ff;
  logic update_ff;
  logic ack_ff;
  logic [7:0] rdata_ff;
  logic cal_start_ff;

  logic take;
  logic wr;
  logic in_pll;
  logic [3:0] pll_idx;
  logic upd_set;
  logic [7:0] act_pwr;
  logic [7:0] act_cal;
  logic [1:0] act_pwr_fld;
  logic [2:0] nxt_ratio;

  // ----------------------------------------------------------------------
  // link decode
  // ----------------------------------------------------------------------
  // a request is taken once; ack_ff high masks the held request
  assign take = link.req && !ack_ff;
  assign wr = take && link.we;
  assign in_pll = (link.addr >= PLL_FIRST_OFS) &&
                  (link.addr <= PLL_LAST_OFS);
  assign pll_idx = 4'(link.addr - PLL_FIRST_OFS);
  assign upd_set = wr && (link.addr == UPDATE_OFS) &&
                   link.wdata[UPDATE_BIT];

  assign act_pwr = act_pll_ff[4'(PWR_POL_OFS - PLL_FIRST_OFS)];
  assign act_cal = act_pll_ff[4'(VCO_CAL_OFS - PLL_FIRST_OFS)];
  assign act_pwr_fld = act_pwr[PWR_LSB +: 2];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= take;
    end
  end

  // ----------------------------------------------------------------------
  // staged registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < PLL_CNT; i++) begin
        stg_pll_ff[i] <= (i == 0) ? PWR_POL_RST : OTHER_RST; // RL1 RL15
      end
    end else if (wr && in_pll) begin
      stg_pll_ff[pll_idx] <= link.wdata;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stg_div_ff <= VCO_DIV_RST; // RL3
      stg_src_ff <= SRC_SEL_RST; // RL1
    end else if (wr) begin
      if (link.addr == VCO_DIV_OFS) begin
        stg_div_ff <= link.wdata;
      end
      if (link.addr == SRC_SEL_OFS) begin
        stg_src_ff <= link.wdata;
      end
    end
  end

  // ----------------------------------------------------------------------
  // update trigger and transfer
  // ----------------------------------------------------------------------
  // the transfer happens the cycle after the trigger is written; a new
  // trigger arriving in that same cycle wins over the self-clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      update_ff <= 1'b0;
    end else if (upd_set) begin
      update_ff <= 1'b1; // RL7
    end else if (update_ff) begin
      update_ff <= 1'b0; // RL16
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < PLL_CNT; i++) begin
        act_pll_ff[i] <= (i == 0) ? PWR_POL_RST : OTHER_RST; // RL1 RL15
      end
      act_div_ff <= VCO_DIV_RST; // RL3
      act_src_ff <= SRC_SEL_RST; // RL1
    end else if (update_ff) begin
      act_pll_ff <= stg_pll_ff; // RL7
      act_div_ff <= stg_div_ff; // RL7
      act_src_ff <= stg_src_ff; // RL7
    end
  end

  // ----------------------------------------------------------------------
  // calibration start
  // ----------------------------------------------------------------------
  // only a 0 to 1 change of the applied bit starts a run, which is why a
  // second run needs the bit cleared and applied first
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cal_start_ff <= 1'b0;
    end else begin
      cal_start_ff <= update_ff && !act_cal[CAL_BIT] && // RL11 RL12
        stg_pll_ff[4'(VCO_CAL_OFS - PLL_FIRST_OFS)][CAL_BIT];
    end
  end

  // ----------------------------------------------------------------------
  // read back
  // ----------------------------------------------------------------------
  // unmapped offsets read as zero and are still acknowledged
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_ff <= 8'h00;
    end else if (take && !link.we) begin
      if (in_pll) begin
        rdata_ff <= stg_pll_ff[pll_idx];
      end else if (link.addr == VCO_DIV_OFS) begin
        rdata_ff <= stg_div_ff;
      end else if (link.addr == SRC_SEL_OFS) begin
        rdata_ff <= stg_src_ff;
      end else if (link.addr == UPDATE_OFS) begin
        rdata_ff <= {7'h00, update_ff}; // RL16
      end else begin
        rdata_ff <= 8'h00;
      end
    end
  end

  // ----------------------------------------------------------------------
  // routing decode
  // ----------------------------------------------------------------------
  // codes above divide-by-6 clamp to 6 so no code yields less than 2
  always_comb begin
    if (act_div_ff[2:0] > DIV_CODE_MAX) begin
      nxt_ratio = DIV_MAX;
    end else begin
      nxt_ratio = act_div_ff[2:0] + DIV_MIN; // RL3 RL4
    end
  end

  logic pll_on_ff;
  logic pfd_pol_ff;
  logic [REF_EN_W-1:0] ref_en_ff;
  logic src_vco_ff;
  logic bypass_ff;
  logic [2:0] div_ff;
  logic int_vco_ff;
  logic fb_clk_ff;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pll_on_ff <= 1'b0; // RL1
      pfd_pol_ff <= 1'b0;
      ref_en_ff <= '0; // RL15
      src_vco_ff <= 1'b0; // RL1
      bypass_ff <= 1'b0; // RL1
      div_ff <= DIV_MAX - DIV_MIN; // RL3
      int_vco_ff <= 1'b0;
      fb_clk_ff <= 1'b1;
    end else begin
      // only 00 runs the pll; 01 and the unused codes power it down
      pll_on_ff <= (act_pwr_fld == PWR_NORMAL); // RL2
      pfd_pol_ff <= act_pwr[PFD_POL_BIT]; // RL8
      ref_en_ff <= act_pll_ff[4'(REF_EN_OFS - PLL_FIRST_OFS)]
                   [REF_EN_LSB +: REF_EN_W];
      src_vco_ff <= act_src_ff[SRC_VCO_BIT]; // RL6
      bypass_ff <= act_src_ff[BYPASS_BIT]; // RL5
      div_ff <= act_src_ff[BYPASS_BIT] ? DIV_ONE : nxt_ratio; // RL4 RL5
      int_vco_ff <= (act_pwr_fld == PWR_NORMAL) &&
                    act_src_ff[SRC_VCO_BIT]; // RL9
      fb_from_clk_calc: begin
        fb_clk_ff <= !act_src_ff[SRC_VCO_BIT]; // RL10
      end
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign link.ack = ack_ff;
  assign link.rdata = rdata_ff;
  assign pll_on_o = pll_on_ff;
  assign pfd_pol_neg_o = pfd_pol_ff;
  assign ref_en_o = ref_en_ff;
  assign src_vco_o = src_vco_ff;
  assign div_bypass_o = bypass_ff;
  assign dist_div_o = div_ff;
  assign int_vco_on_o = int_vco_ff;
  assign fb_from_clk_in_o = fb_clk_ff;
  assign cal_start_o = cal_start_ff;
  assign pll_cfg_o = act_pll_ff;

endmodule // clk_route_dev

// ===== verilog/clk_route_host.sv
// host controller: wishbone slave that issues single link accesses
// assumes: software sequences calibration clears and pll setup itself
module clk_route_host (
  input wire logic clk_i,
  input wire logic rst_i,
  clk_route_if.host link,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);
  import clk_route_pkg::*;

  // ----------------------------------------------------------------------
  // wishbone slave
  // ----------------------------------------------------------------------
  logic ack_ff;
  logic [31:0] dat_ff;
  logic [9:0] addr_ff;
  logic [7:0] wdata_ff;
  logic we_ff;
  logic req_ff;
  logic [7:0] rdata_ff;
  host_state_t state_ff;
  logic acc;
  logic go;

  assign acc = wb_cyc_i && wb_stb_i && !ack_ff;
  // a go written while busy is ignored; busy shows in status bit 0
  assign go = acc && wb_we_i && (wb_adr_i == H_CTRL_OFS) && wb_sel_i[0] &&
              wb_dat_i[H_GO_BIT] && (state_ff == H_IDLE);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= acc;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      addr_ff <= 10'h000;
      wdata_ff <= 8'h00;
    end else if (acc && wb_we_i && state_ff == H_IDLE) begin
      if (wb_adr_i == H_ADDR_OFS) begin
        if (wb_sel_i[0]) addr_ff[7:0] <= wb_dat_i[7:0];
        if (wb_sel_i[1]) addr_ff[9:8] <= wb_dat_i[9:8];
      end
      if (wb_adr_i == H_WDATA_OFS && wb_sel_i[0]) begin
        wdata_ff <= wb_dat_i[7:0];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_ff <= 32'h0000_0000;
    end else if (acc && !wb_we_i) begin
      case (wb_adr_i)
        H_ADDR_OFS: dat_ff <= {22'h00_0000, addr_ff};
        H_WDATA_OFS: dat_ff <= {24'h00_0000, wdata_ff};
        H_CTRL_OFS: dat_ff <= {30'h0000_0000, we_ff, 1'b0};
        H_STAT_OFS: dat_ff <= {16'h0000, rdata_ff, 7'h00,
                               state_ff != H_IDLE};
        default: dat_ff <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // link master
  // ----------------------------------------------------------------------
  // the gap state lets the device drop ack before the next request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= H_IDLE;
      req_ff <= 1'b0;
      we_ff <= 1'b0;
      rdata_ff <= 8'h00;
    end else begin
      case (state_ff)
        H_IDLE: begin
          if (go) begin
            we_ff <= wb_dat_i[H_WE_BIT];
            req_ff <= 1'b1; // RL7 RL11
            state_ff <= H_REQ;
          end
        end
        H_REQ: begin
          if (link.ack) begin
            if (!we_ff) rdata_ff <= link.rdata;
            req_ff <= 1'b0;
            state_ff <= H_GAP;
          end
        end
        H_GAP: state_ff <= H_IDLE;
        default: state_ff <= H_IDLE;
      endcase
    end
  end

  assign link.req = req_ff;
  assign link.we = we_ff;
  assign link.addr = addr_ff;
  assign link.wdata = wdata_ff;
  assign wb_ack_o = ack_ff;
  assign wb_dat_o = dat_ff;

endmodule // clk_route_host

// ===== dv/clk_route_props.sv
// checker for the host-device link and the routing outputs of the device
// assumes: one clock, sync active-high reset, instantiated by the bench
module clk_route_props (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic req,
  input wire logic we,
  input wire logic [9:0] addr,
  input wire logic [7:0] wdata,
  input wire logic ack,
  input wire logic pll_on_o,
  input wire logic src_vco_o,
  input wire logic div_bypass_o,
  input wire logic [2:0] dist_div_o,
  input wire logic int_vco_on_o,
  input wire logic fb_from_clk_in_o,
  input wire logic cal_start_o
);
  timeunit 1ns;
  timeprecision 1ns;
  import clk_route_pkg::*;
  // ------------------------------------------------------------------
  // update history
  // ------------------------------------------------------------------
  // routing may only move a few cycles behind a taken update write
  logic upd_take;
  logic [4:0] upd_hist_ff;
  assign upd_take = req && !ack && we && (addr == UPDATE_OFS)
                    && wdata[UPDATE_BIT];
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      upd_hist_ff <= 5'h00;
    end else begin
      upd_hist_ff <= {upd_hist_ff[3:0], upd_take};
    end
  end
  // ------------------------------------------------------------------
  // properties
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence take_s;
    req && !ack;
  endsequence
  sequence held_s;
    req && ack && $stable({we, addr, wdata});
  endsequence
  ack_pulse_a: assert property (ack |=> !ack)
    else $error("link ack longer than one cycle");
  req_answer_a: assert property (take_s |=> held_s)
    else $error("link request not held or not answered");
  req_release_a: assert property (ack |=> !req)
    else $error("link request not released after ack");
  route_gate_a: assert property (
    $changed({pll_on_o, src_vco_o, div_bypass_o, dist_div_o})
    |-> |upd_hist_ff) else $error("routing moved without update");
  cal_gate_a: assert property (cal_start_o |-> |upd_hist_ff)
    else $error("calibration without update");
  cal_pulse_a: assert property (cal_start_o |=> !cal_start_o)
    else $error("calibration start not a pulse");
  vco_off_a: assert property (
    !src_vco_o |-> !int_vco_on_o && fb_from_clk_in_o)
    else $error("internal vco on with clock input source");
  div_floor_a: assert property (
    !div_bypass_o |-> dist_div_o >= DIV_MIN && dist_div_o <= DIV_MAX)
    else $error("divider ratio out of range");
  bypass_one_a: assert property (
    div_bypass_o |-> dist_div_o == DIV_ONE)
    else $error("bypass does not skip divider");
endmodule // clk_route_props

// ===== dv/clock_source_routing_config_tb.sv
// bench: wishbone host end and device end joined by the link interface
// assumes: one 25 MHz clock, synchronous active-high reset held 3 cycles
module clock_source_routing_config_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import clk_route_pkg::*;
  `define CHK(a, e) \
    begin \
      cmp_count++; \
      if ((a) !== (e)) begin \
        err_total++; \
        $display("wrong value at %0t: got %0h want %0h", $time, a, e); \
      end \
    end
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic wwe = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic wack, pll_on, pfd_neg, src_vco, byp, int_vco, fb_clk, cal_start;
  logic [2:0] ref_en, dist_div;
  logic [7:0] pll_cfg [0:PLL_CNT-1];
  logic [7:0] q;
  int err_total = 0;
  int cmp_count = 0;
  int cal_n = 0;
  always #20 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    if (cal_start === 1'b1) cal_n++;
  end
  clk_route_if lk();
  clk_route_dev clk_route_dev_i (
    .clk_i(clk_i), .rst_i(rst_i), .link(lk), .pll_on_o(pll_on),
    .pfd_pol_neg_o(pfd_neg), .ref_en_o(ref_en), .src_vco_o(src_vco),
    .div_bypass_o(byp), .dist_div_o(dist_div), .int_vco_on_o(int_vco),
    .fb_from_clk_in_o(fb_clk), .cal_start_o(cal_start), .pll_cfg_o(pll_cfg)
  );
  clk_route_host clk_route_host_i (
    .clk_i(clk_i), .rst_i(rst_i), .link(lk), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(wwe), .wb_adr_i(adr), .wb_sel_i(4'hF),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(wack)
  );
  clk_route_props clk_route_props_i (
    .clk_i(clk_i), .rst_i(rst_i), .req(lk.req), .we(lk.we),
    .addr(lk.addr), .wdata(lk.wdata), .ack(lk.ack), .pll_on_o(pll_on),
    .src_vco_o(src_vco), .div_bypass_o(byp), .dist_div_o(dist_div),
    .int_vco_on_o(int_vco), .fb_from_clk_in_o(fb_clk),
    .cal_start_o(cal_start)
  );
  // ------------------------------------------------------------------
  // bus tasks
  // ------------------------------------------------------------------
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic wb(input logic w, input logic [3:0] a,
                    input logic [31:0] d, output logic [31:0] r);
    cyc <= 1'b1;
    stb <= 1'b1;
    wwe <= w;
    adr <= a;
    wdat <= d;
    @(posedge clk_i);
    for (int n = 0; n < 50 && wack !== 1'b1; n++) @(posedge clk_i);
    if (wack !== 1'b1) begin
      err_total++;
      close_out();
    end
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask
  // one link access; waits for busy to clear, then for routing to land
  task automatic dev(input logic w, input logic [9:0] a,
                     input logic [7:0] d, output logic [7:0] r);
    logic [31:0] s;
    wb(1'b1, H_ADDR_OFS, {22'h0, a}, s);
    wb(1'b1, H_WDATA_OFS, {24'h0, d}, s);
    wb(1'b1, H_CTRL_OFS, {30'h0, w, 1'b1}, s);
    s = 32'h1;
    for (int n = 0; n < 20 && s[H_BUSY_BIT] !== 1'b0; n++) begin
      wb(1'b0, H_STAT_OFS, 32'h0, s);
    end
    if (s[H_BUSY_BIT] !== 1'b0) begin
      err_total++;
      close_out();
    end
    r = s[H_RDATA_LSB +: 8];
    repeat (3) @(posedge clk_i);
  endtask
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    dev(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [9:0] a, input logic [7:0] e);
    dev(1'b0, a, 8'h00, q);
    `CHK(q, e);
  endtask
  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  task automatic t_reset;
    `CHK(pll_on, 1'b0);
    `CHK(src_vco, 1'b0);
    `CHK(byp, 1'b0);
    `CHK(dist_div, 3'h4);
    `CHK(ref_en, 3'h0);
    `CHK(int_vco, 1'b0);
    `CHK(fb_clk, 1'b1);
    rd(PWR_POL_OFS, 8'h01);
    rd(VCO_DIV_OFS, 8'h02);
    rd(SRC_SEL_OFS, 8'h00);
    $display("reset defaults done");
  endtask
  task automatic t_apply;
    // the internal vco runs far above the channel divider limit, so the
    // host keeps the vco divider in the path while it is the source
    wr(SRC_SEL_OFS, 8'h02);
    wr(PWR_POL_OFS, 8'h80);
    wr(REF_EN_OFS, 8'h05);
    `CHK(src_vco, 1'b0);
    `CHK(pll_on, 1'b0);
    wr(UPDATE_OFS, 8'h01);
    rd(UPDATE_OFS, 8'h00);
    `CHK(src_vco, 1'b1);
    `CHK(byp, 1'b0);
    `CHK(dist_div, 3'h4);
    `CHK(pll_on, 1'b1);
    `CHK(pfd_neg, 1'b1);
    `CHK(int_vco, 1'b1);
    `CHK(fb_clk, 1'b0);
    `CHK(ref_en, 3'h5);
    `CHK(pll_cfg[0], 8'h80);
    // clock input with the divider bypassed, pll running on it
    wr(SRC_SEL_OFS, 8'h01);
    wr(PWR_POL_OFS, 8'h00);
    wr(UPDATE_OFS, 8'h01);
    `CHK(byp, 1'b1);
    `CHK(dist_div, DIV_ONE);
    `CHK(src_vco, 1'b0);
    `CHK(pll_on, 1'b1);
    `CHK(int_vco, 1'b0);
    `CHK(fb_clk, 1'b1);
    `CHK(pfd_neg, 1'b0);
    wr(SRC_SEL_OFS, 8'h00);
    wr(PWR_POL_OFS, 8'h01);
    wr(UPDATE_OFS, 8'h01);
    `CHK(pll_on, 1'b0);
    `CHK(byp, 1'b0);
    `CHK(dist_div, 3'h4);
    $display("apply on update done");
  endtask
  task automatic t_div;
    logic [2:0] exp;
    for (int c = 0; c < 8; c++) begin
      wr(VCO_DIV_OFS, 8'(c));
      wr(UPDATE_OFS, 8'h01);
      exp = (c > 4) ? DIV_MAX : 3'(c + 2);
      `CHK(dist_div, exp);
    end
    $display("divider ratios done");
  endtask
  task automatic t_cal;
    wr(VCO_CAL_OFS, 8'h01);
    `CHK(cal_n, 0);
    wr(UPDATE_OFS, 8'h01);
    `CHK(cal_n, 1);
    wr(UPDATE_OFS, 8'h01);
    `CHK(cal_n, 1);
    wr(VCO_CAL_OFS, 8'h00);
    wr(UPDATE_OFS, 8'h01);
    wr(VCO_CAL_OFS, 8'h01);
    wr(UPDATE_OFS, 8'h01);
    `CHK(cal_n, 2);
    $display("calibration done");
  endtask
  task automatic t_unmapped;
    wr(10'h100, 8'hA5);
    rd(10'h100, 8'h00);
    rd(VCO_CAL_OFS, 8'h01);
    $display("unmapped access done");
  endtask
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    t_apply();
    t_div();
    t_cal();
    t_unmapped();
    close_out();
  end
  initial begin
    repeat (100000) @(posedge clk_i);
    err_total++;
    close_out();
  end
endmodule // clock_source_routing_config_tb
